// ==== src/hms_regs.v ====
// Function
// - Standby beep only while enable bit set
// - Sensor one offset register, added to sample
// - Sensor two offset register, added to sample
// - First live status register, read only
// - Fan two and one speed flags
// - Sensor two and one heat flags
// - Five and three volt input flags
// - Core supply A flag, bit one reserved
// - Second live status register, read only
// - Chassis open flag follows sensor input
// - Negative five and twelve volt flags
// - Twelve volt input flag
// - Third live status register, read only
// - Battery and standby rail flags
// - Identification pins driven only when enabled
// - Identification levels from low five bits
// - Locations 57h, 58h, 5Ch reserved
// - Rail out of range above high/below low
`timescale 1ns/1ps
`include "hms_map.vh"

module hms_regs #(
    parameter TW = 8,
    parameter VW = 8,
    parameter NPIN = 5
)
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Temperature samples from the converter
    input wire [TW-1:0] temp1_raw_i,
    input wire temp1_vld_i,
    input wire [TW-1:0] temp1_limit_i,
    input wire [TW-1:0] temp2_raw_i,
    input wire temp2_vld_i,
    input wire [TW-1:0] temp2_limit_i,
    // Reported temperatures
    output reg [TW-1:0] temp1_o,
    output reg [TW-1:0] temp2_o,
    // Comparison results from the monitor engine
    input wire fan_one_speed_i,
    input wire fan_two_speed_i,
    input wire five_volt_input_i,
    input wire three_volt_input_i,
    input wire core_supply_a_i,
    input wire neg_five_volt_i,
    input wire neg_twelve_volt_i,
    input wire twelve_volt_input_i,
    // Standby and battery rail readings and limits
    input wire [VW-1:0] standby_rdg_i,
    input wire [VW-1:0] standby_hi_i,
    input wire [VW-1:0] standby_lo_i,
    input wire [VW-1:0] battery_rdg_i,
    input wire [VW-1:0] battery_hi_i,
    input wire [VW-1:0] battery_lo_i,
    // Chassis sensor pin
    input wire chassis_open_pin_i,
    // Beep and identification pins
    output reg standby_beep_o,
    output reg [NPIN-1:0] voltage_identification_pins_o,
    output reg [NPIN-1:0] voltage_identification_pins_oe_o
);

    // Register index from the word address
    function hit;
        input [9:0] adr;
        input [7:0] idx;
        begin
            hit = (adr[9:2] == idx);
        end
    endfunction

    // Out of range if beyond either limit
    function oor;
        input [VW-1:0] rdg;
        input [VW-1:0] hi;
        input [VW-1:0] lo;
        begin
            oor = (rdg > hi) || (rdg < lo);
        end
    endfunction

    wire req;
    wire wr;
    wire rd;
    wire sel_beep;
    wire sel_ofs1;
    wire sel_ofs2;
    wire sel_vid;
    wire sb_oor;
    wire bat_oor;
    wire [TW-1:0] raw [0:1];
    wire [TW-1:0] lim [0:1];
    wire vld [0:1];
    wire [TW-1:0] adj [0:1];
    wire [TW-1:0] rpt_q [0:1];
    wire heat_q [0:1];

    reg beep_en_r;
    reg [TW-1:0] ofs1_r;
    reg [TW-1:0] ofs2_r;
    reg [7:0] sts1_r;
    reg [7:0] sts2_r;
    reg [7:0] sts3_r;
    reg [NPIN-1:0] vid_lvl_r;
    reg vid_en_r;
    reg case_meta_r;
    reg case_sync_r;
    reg [31:0] rd_nxt;
    reg [7:0] sts1_nxt;
    reg [7:0] sts2_nxt;
    reg [7:0] sts3_nxt;
    reg beep_nxt;
    reg [NPIN-1:0] vid_oe_nxt;

    // Reset words, cut to the field widths where they meet them
    localparam [7:0] VID_RST = `HMS_RST_VID;
    localparam [7:0] STS_RST = `HMS_RST_STS;

    // Write lands at the edge that raises ack
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;

    // Status, reserved and unmapped words have no select: writes vanish
    assign sel_beep = wr && hit(wb_adr_i, `HMS_IDX_BEEP);
    assign sel_ofs1 = wr && hit(wb_adr_i, `HMS_IDX_OFS1);
    assign sel_ofs2 = wr && hit(wb_adr_i, `HMS_IDX_OFS2);
    assign sel_vid = wr && hit(wb_adr_i, `HMS_IDX_VID);

    assign raw[0] = temp1_raw_i;
    assign raw[1] = temp2_raw_i;
    assign lim[0] = temp1_limit_i;
    assign lim[1] = temp2_limit_i;
    assign vld[0] = temp1_vld_i;
    assign vld[1] = temp2_vld_i;
    assign adj[0] = raw[0] + ofs1_r;
    assign adj[1] = raw[1] + ofs2_r;

    // Rail limits are compared here; the engine sends readings and limits, not flags
    assign sb_oor = oor(standby_rdg_i, standby_hi_i, standby_lo_i);
    assign bat_oor = oor(battery_rdg_i, battery_hi_i, battery_lo_i);

    // One path per sensor; the flag uses the offset-corrected sample
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : g_temp
            reg [TW-1:0] rpt_r;
            reg heat_r;
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    rpt_r <= {TW{1'b0}};
                    heat_r <= 1'b0;
                end
                else if (vld[g])
                begin
                    rpt_r <= adj[g];
                    heat_r <= (adj[g] > lim[g]);
                end
            end
            assign rpt_q[g] = rpt_r;
            assign heat_q[g] = heat_r;
        end
    endgenerate

    // Chassis pin crosses from outside; first stage read only by second
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            case_meta_r <= 1'b0;
            case_sync_r <= 1'b0;
        end
        else
        begin
            case_meta_r <= chassis_open_pin_i;
            case_sync_r <= case_meta_r;
        end
    end

    // Live status words; reserved bits stay low
    always @*
    begin
        sts1_nxt = STS_RST;
        sts1_nxt[`HMS_S1_FAN2] = fan_two_speed_i;
        sts1_nxt[`HMS_S1_FAN1] = fan_one_speed_i;
        sts1_nxt[`HMS_S1_TEMP2] = heat_q[1];
        sts1_nxt[`HMS_S1_TEMP1] = heat_q[0];
        sts1_nxt[`HMS_S1_P5V] = five_volt_input_i;
        sts1_nxt[`HMS_S1_P3V3] = three_volt_input_i;
        sts1_nxt[`HMS_S1_CORE_A] = core_supply_a_i;
        sts2_nxt = STS_RST;
        sts2_nxt[`HMS_S2_CASE] = case_sync_r;
        sts2_nxt[`HMS_S2_N5V] = neg_five_volt_i;
        sts2_nxt[`HMS_S2_N12V] = neg_twelve_volt_i;
        sts2_nxt[`HMS_S2_P12V] = twelve_volt_input_i;
        sts3_nxt = STS_RST;
        sts3_nxt[`HMS_S3_BAT] = bat_oor;
        sts3_nxt[`HMS_S3_SB] = sb_oor;
    end

    // Not latched: a flag clears at the edge after its input does
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sts1_r <= STS_RST;
            sts2_r <= STS_RST;
            sts3_r <= STS_RST;
        end
        else
        begin
            sts1_r <= sts1_nxt;
            sts2_r <= sts2_nxt;
            sts3_r <= sts3_nxt;
        end
    end

    // Standby beep enable
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            beep_en_r <= `HMS_RST_BEEP_EN;
        end
        else if (sel_beep)
        begin
            beep_en_r <= wb_dat_i[`HMS_BEEP_SB_BIT];
        end
    end

    // Offsets apply from the next sample on, never to a held one
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ofs1_r <= `HMS_RST_OFS;
        end
        else if (sel_ofs1)
        begin
            ofs1_r <= wb_dat_i[TW-1:0];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ofs2_r <= `HMS_RST_OFS;
        end
        else if (sel_ofs2)
        begin
            ofs2_r <= wb_dat_i[TW-1:0];
        end
    end

    // Levels and enable share one word
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            vid_lvl_r <= VID_RST[NPIN-1:0];
            vid_en_r <= VID_RST[`HMS_VID_EN_BIT];
        end
        else if (sel_vid)
        begin
            vid_lvl_r <= wb_dat_i[`HMS_VID_LVL_MSB:`HMS_VID_LVL_LSB];
            vid_en_r <= wb_dat_i[`HMS_VID_EN_BIT];
        end
    end

    // Read mux; reserved and unmapped words read zero
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        case (wb_adr_i[9:2])
            `HMS_IDX_BEEP:
                rd_nxt[`HMS_BEEP_SB_BIT] = beep_en_r;
            `HMS_IDX_OFS1:
                rd_nxt[TW-1:0] = ofs1_r;
            `HMS_IDX_OFS2:
                rd_nxt[TW-1:0] = ofs2_r;
            `HMS_IDX_STS1:
                rd_nxt[7:0] = sts1_r;
            `HMS_IDX_STS2:
                rd_nxt[7:0] = sts2_r;
            `HMS_IDX_STS3:
                rd_nxt[7:0] = sts3_r;
            `HMS_IDX_VID:
            begin
                rd_nxt[`HMS_VID_LVL_MSB:`HMS_VID_LVL_LSB] = vid_lvl_r;
                rd_nxt[`HMS_VID_EN_BIT] = vid_en_r;
            end
            `HMS_IDX_RSV57, `HMS_IDX_RSV58, `HMS_IDX_RSV5C:
                rd_nxt = 32'h0000_0000;
            default:
                rd_nxt = 32'h0000_0000;
        endcase
    end

    // Ack one cycle after the request, dropped the next
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
        end
        else
        begin
            wb_ack_o <= req;
        end
    end

    // Read word held until the next read
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_dat_o <= 32'h0000_0000;
        end
        else if (rd)
        begin
            wb_dat_o <= rd_nxt;
        end
    end

    // Beep waits for the registered flag, one edge behind status
    // All enables are one bit, so the pins switch together
    always @*
    begin
        beep_nxt = sts3_r[`HMS_S3_SB] && beep_en_r;
        vid_oe_nxt = {NPIN{vid_en_r}};
    end

    // Beep and temperature outputs; all outputs from flops
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            standby_beep_o <= 1'b0;
            temp1_o <= {TW{1'b0}};
            temp2_o <= {TW{1'b0}};
        end
        else
        begin
            standby_beep_o <= beep_nxt;
            temp1_o <= rpt_q[0];
            temp2_o <= rpt_q[1];
        end
    end

    // Identification pin drivers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            voltage_identification_pins_o <= {NPIN{1'b0}};
            voltage_identification_pins_oe_o <= {NPIN{1'b0}};
        end
        else
        begin
            voltage_identification_pins_o <= vid_lvl_r;
            voltage_identification_pins_oe_o <= vid_oe_nxt;
        end
    end

endmodule

// ==== pkg/hms_map.vh ====
`ifndef HMS_MAP_VH
`define HMS_MAP_VH
// Register indices; byte address is four times the index
`define HMS_IDX_BEEP 8'h53
`define HMS_IDX_OFS1 8'h54
`define HMS_IDX_OFS2 8'h55
`define HMS_IDX_RSV57 8'h57
`define HMS_IDX_RSV58 8'h58
`define HMS_IDX_STS1 8'h59
`define HMS_IDX_STS2 8'h5a
`define HMS_IDX_STS3 8'h5b
`define HMS_IDX_RSV5C 8'h5c
`define HMS_IDX_VID 8'h5d
// Reset values
`define HMS_RST_BEEP_EN 1'h1
`define HMS_RST_OFS 8'h00
`define HMS_RST_STS 8'h00
`define HMS_RST_VID 8'h00
// Field positions
`define HMS_BEEP_SB_BIT 0
`define HMS_S1_FAN2 7
`define HMS_S1_FAN1 6
`define HMS_S1_TEMP2 5
`define HMS_S1_TEMP1 4
`define HMS_S1_P5V 3
`define HMS_S1_P3V3 2
`define HMS_S1_CORE_A 0
`define HMS_S2_CASE 4
`define HMS_S2_N5V 2
`define HMS_S2_N12V 1
`define HMS_S2_P12V 0
`define HMS_S3_BAT 1
`define HMS_S3_SB 0
`define HMS_VID_EN_BIT 7
`define HMS_VID_LVL_MSB 4
`define HMS_VID_LVL_LSB 0
`endif

// ==== testbench/hms_regs_monitor.sv ====
`timescale 1ns/1ps
module hms_regs_monitor (
    // Clock, reset and bus
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i, wb_dat_o,
    // Monitor inputs and pins
    input wire fan_one_speed_i, fan_two_speed_i, five_volt_input_i,
    input wire three_volt_input_i, core_supply_a_i, neg_five_volt_i,
    input wire neg_twelve_volt_i, twelve_volt_input_i, standby_beep_o,
    input wire [7:0] standby_rdg_i, standby_hi_i, standby_lo_i,
    input wire [7:0] battery_rdg_i, battery_hi_i, battery_lo_i,
    input wire [4:0] voltage_identification_pins_o,
    input wire [4:0] voltage_identification_pins_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    reg [1:0] live_r;
    wire [7:0] idx = wb_adr_i[9:2];
    wire sb_bad = standby_rdg_i > standby_hi_i || standby_rdg_i < standby_lo_i;
    wire bt_bad = battery_rdg_i > battery_hi_i || battery_rdg_i < battery_lo_i;
    // Reads just after reset would see pre-reset inputs
    always @(posedge clk_i)
        if (rst_i) live_r <= 2'h0;
        else if (live_r != 2'h3) live_r <= live_r + 2'h1;
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd(logic [7:0] a);
        s_take ##0 (!wb_we_i && idx == a && live_r == 2'h3);
    endsequence
    property p_vid;
        logic [7:0] d;
        (s_take ##0 (wb_we_i && wb_sel_i[0] && idx == 8'h5d), d = wb_dat_i[7:0])
        |-> ##2 (voltage_identification_pins_o == d[4:0]
        && voltage_identification_pins_oe_o == {5{d[7]}});
    endproperty
    AST_ACK_RESP: assert property (s_take |=> wb_ack_o)
        else $error("request not acknowledged");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_STS1: assert property (s_rd(8'h59) |=> wb_dat_o == {24'h0,
        $past(fan_two_speed_i, 2), $past(fan_one_speed_i, 2), wb_dat_o[5:4],
        $past(five_volt_input_i, 2), $past(three_volt_input_i, 2), 1'b0,
        $past(core_supply_a_i, 2)}) else $error("first status mismatch");
    AST_STS2: assert property (s_rd(8'h5a) |=> wb_dat_o[31:5] == 27'h0 &&
        wb_dat_o[3:0] == {1'b0, $past(neg_five_volt_i, 2),
        $past(neg_twelve_volt_i, 2), $past(twelve_volt_input_i, 2)})
        else $error("second status mismatch");
    AST_STS3: assert property (s_rd(8'h5b) |=>
        wb_dat_o == {30'h0, $past(bt_bad, 2), $past(sb_bad, 2)})
        else $error("third status mismatch");
    AST_RSV: assert property (s_take ##0 (!wb_we_i &&
        (idx == 8'h57 || idx == 8'h58 || idx == 8'h5c)) |=> wb_dat_o == 32'h0)
        else $error("reserved read not zero");
    AST_VID: assert property (p_vid)
        else $error("identification pins wrong");
    AST_BEEP: assert property (standby_beep_o |-> $past(sb_bad, 2))
        else $error("beep without standby fault");
endmodule
bind hms_regs hms_regs_monitor hms_regs_monitor_inst (.*);

// ==== testbench/tb_hw_monitor_status_offset_vid_regs.sv ====
`timescale 1ns/1ps
module tb_hw_monitor_status_offset_vid_regs;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    reg [9:0] wb_adr_i = 10'h0;
    wire [3:0] wb_sel_i = 4'h1;
    reg [31:0] wb_dat_i = 32'h0;
    reg [7:0] temp1_raw_i = 8'h0, temp1_limit_i = 8'h0;
    reg temp1_vld_i = 1'b0, chassis_open_pin_i = 1'b0;
    reg [7:0] lv = 8'h0, standby_rdg_i = 8'h60, battery_rdg_i = 8'h60;
    reg [7:0] standby_hi_i = 8'h80, standby_lo_i = 8'h40;
    // Both sensors share one stimulus; offsets tell them apart
    wire [7:0] temp2_raw_i = temp1_raw_i, temp2_limit_i = temp1_limit_i;
    wire temp2_vld_i = temp1_vld_i;
    wire [7:0] battery_hi_i = standby_hi_i, battery_lo_i = standby_lo_i;
    wire fan_one_speed_i = lv[0], fan_two_speed_i = lv[1];
    wire five_volt_input_i = lv[2], three_volt_input_i = lv[3];
    wire core_supply_a_i = lv[4], neg_five_volt_i = lv[5];
    wire neg_twelve_volt_i = lv[6], twelve_volt_input_i = lv[7];
    wire [31:0] wb_dat_o;
    wire wb_ack_o, standby_beep_o;
    wire [7:0] temp1_o, temp2_o;
    wire [4:0] voltage_identification_pins_o, voltage_identification_pins_oe_o;
    integer bad_count = 0, checks = 0, i;
    reg [31:0] r;

    hms_regs hms_regs_inst (.*);
    always #50 clk_i = ~clk_i;

    task test_done;
    begin
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task chk(input [31:0] g, input [31:0] e);
    begin
        checks = checks + 1;
        if (g !== e)
        begin
            bad_count = bad_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    end
    endtask
    task bus(input w, input [7:0] a, input [7:0] d);
        integer n;
    begin
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {a, 2'b00};
        wb_dat_i <= {24'h0, d};
        n = 0;
        // Ack is looked at once the edge has settled
        @(posedge clk_i);
        #1;
        while (wb_ack_o !== 1'b1 && n < 8)
        begin
            n = n + 1;
            @(posedge clk_i);
            #1;
        end
        if (wb_ack_o !== 1'b1)
        begin
            bad_count = bad_count + 1;
            test_done;
        end
        // Release only at the edge that samples ack high
        @(posedge clk_i);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
    begin
        bus(1'b0, a, 8'h00);
        chk(r, e);
    end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge clk_i);
    endtask

    task t_reset;
    begin
        rdc(8'h54, 32'h0);
        rdc(8'h55, 32'h0);
        rdc(8'h59, 32'h0);
        rdc(8'h5a, 32'h0);
        rdc(8'h5b, 32'h0);
        rdc(8'h5d, 32'h0);
        rdc(8'h53, 32'h1);
    end
    endtask
    task t_levels;
    begin
        for (i = 0; i < 8; i = i + 1)
        begin
            lv <= 8'h01 << i;
            tick(3);
            rdc(8'h59, {24'h0, i == 1, i == 0, 2'b00, i == 2,
                i == 3, 1'b0, i == 4});
            rdc(8'h5a, {29'h0, i == 5, i == 6, i == 7});
        end
        bus(1'b1, 8'h59, 8'hff);
        bus(1'b1, 8'h5a, 8'hff);
        lv <= 8'h00;
        tick(3);
        rdc(8'h59, 32'h0);
        rdc(8'h5a, 32'h0);
    end
    endtask
    task t_case;
    begin
        chassis_open_pin_i <= 1'b1;
        tick(5);
        rdc(8'h5a, 32'h10);
        chassis_open_pin_i <= 1'b0;
        tick(5);
        rdc(8'h5a, 32'h0);
    end
    endtask
    task t_temp;
    begin
        bus(1'b1, 8'h54, 8'ha5);
        bus(1'b1, 8'h55, 8'h5a);
        rdc(8'h54, 32'ha5);
        rdc(8'h55, 32'h5a);
        bus(1'b1, 8'h54, 8'h0a);
        bus(1'b1, 8'h55, 8'h00);
        temp1_raw_i <= 8'h14;
        temp1_limit_i <= 8'h19;
        temp1_vld_i <= 1'b1;
        tick(1);
        temp1_vld_i <= 1'b0;
        tick(3);
        chk({24'h0, temp1_o}, 32'h1e);
        chk({24'h0, temp2_o}, 32'h14);
        rdc(8'h59, 32'h10);
    end
    endtask
    task t_rail;
    begin
        standby_rdg_i <= 8'h90;
        tick(4);
        rdc(8'h5b, 32'h1);
        chk({31'h0, standby_beep_o}, 32'h1);
        standby_rdg_i <= 8'h3f;
        battery_rdg_i <= 8'h81;
        tick(4);
        rdc(8'h5b, 32'h3);
        standby_rdg_i <= 8'h40;
        battery_rdg_i <= 8'h80;
        tick(4);
        rdc(8'h5b, 32'h0);
        chk({31'h0, standby_beep_o}, 32'h0);
        bus(1'b1, 8'h53, 8'h00);
        standby_rdg_i <= 8'hff;
        tick(4);
        chk({31'h0, standby_beep_o}, 32'h0);
        bus(1'b1, 8'h53, 8'h01);
        tick(3);
        chk({31'h0, standby_beep_o}, 32'h1);
    end
    endtask
    task t_vid;
    begin
        bus(1'b1, 8'h5d, 8'h95);
        tick(2);
        chk({27'h0, voltage_identification_pins_o}, 32'h15);
        chk({27'h0, voltage_identification_pins_oe_o}, 32'h1f);
        rdc(8'h5d, 32'h95);
        bus(1'b1, 8'h5d, 8'h0a);
        tick(2);
        chk({27'h0, voltage_identification_pins_oe_o}, 32'h0);
        chk({27'h0, voltage_identification_pins_o}, 32'h0a);
    end
    endtask
    task t_rsv;
    begin
        bus(1'b1, 8'h57, 8'hff);
        bus(1'b1, 8'h5c, 8'hff);
        rdc(8'h57, 32'h0);
        rdc(8'h58, 32'h0);
        rdc(8'h5c, 32'h0);
        rdc(8'h70, 32'h0);
    end
    endtask

    initial
    begin
        tick(10);
        rst_i <= 1'b0;
        t_reset;
        t_levels;
        t_case;
        t_temp;
        t_rail;
        t_vid;
        t_rsv;
        test_done;
    end
endmodule
